// *** icd_decoder.sv ***
`timescale 1ns/10ps
// How it works
// (RULE1) lengths run two to five bytes; far-pointer immediate takes six, copy memory-memory four to six
// (RULE2) bytes one and two always come first, before any extra bytes
// (RULE3) operand selector is bits 7..5 of the first byte
// (RULE4) selector read as register, bit number, or pointer where only 0,1,2,4 are valid
// (RULE5) extra-length field bits 4..3: 00 none, 01 one byte, 10 two bytes
// (RULE6) code 11 only for lock_test_set: data byte then displacement byte
// (RULE7) transfer displacements signed: 8-bit short, 16-bit long low byte first
// (RULE8) byte immediates carry one data byte, word immediates two, low first
// (RULE9) displacement and immediate bytes follow the offset byte when present
// (RULE10) mode field: base, base+offset, base+index, base+index with post-increment
// (RULE11) bit 0 of first byte picks byte (0) or word (1) operand
// (RULE12) opcode is second byte bits 7..2 alone; the size bit does not select it
// (RULE13) base select bits 1..0 of byte two: gen_ptr_a, gen_ptr_b, gen_ptr_c, param_block_ptr
// (RULE14) mode 01 adds the unsigned offset byte to the chosen base
// (RULE15) mode 10 adds index_reg to base, 16-bit result, no sign extension
// (RULE16) mode 11 as mode 10, then index_next rises by one if byte_accessed is high in the done cycle
// (RULE17) copy memory-memory: source half 100100, destination half 110011, each own fields; the destination opcode is not checked
// (RULE18) copy var: 100000 memory-to-register, 100001 register-to-memory, size bit picks width
// (RULE19) far pointer immediate: first byte low 10001, second 00001000, then four bytes
// (RULE20) copy_pointer: 100011 memory-to-pointer, 100110 pointer-to-memory, word size
// (RULE21) sum var: 101000 memory-to-register, 110100 register-to-memory
// (RULE22) word add-immediate: 00100000 register form, 110000 memory form, data after offset
// (RULE23) unmatched first and second byte combinations raise an illegal flag
// (RULE24) total length is reported so the fetch unit can advance past it
module icd_decoder #(
  parameter int ADDR_W = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              byte_valid,
  input  wire logic [7:0]        byte_data,
  output logic                   byte_ready,
  input  wire logic [ADDR_W-1:0] gen_ptr_a,
  input  wire logic [ADDR_W-1:0] gen_ptr_b,
  input  wire logic [ADDR_W-1:0] gen_ptr_c,
  input  wire logic [ADDR_W-1:0] param_block_ptr,
  input  wire logic [ADDR_W-1:0] index_reg,
  input  wire logic              byte_accessed,
  output logic                   done,
  output logic                   illegal,
  output logic [2:0]             instr_len,
  output icd_pkg::icd_fam_t      family,
  output logic [2:0]             op_sel,
  output logic                   sel_ptr_ok,
  output logic                   word_op,
  output logic [1:0]             addr_mode,
  output logic [1:0]             base_sel,
  output logic [7:0]             offset,
  output logic [15:0]            imm_data,
  output logic [15:0]            disp,
  output logic [ADDR_W-1:0]      eff_addr,
  output logic [ADDR_W-1:0]      dst_addr,
  output logic [ADDR_W-1:0]      index_next
);
  typedef enum logic [1:0] {ICD_IDLE, ICD_HEAD, ICD_TAIL, ICD_DONE} icd_state_t;

  typedef struct packed {
    icd_state_t         st;
    logic [7:0]         b1;
    logic [7:0]         b2;
    logic [2:0]         cnt;
    logic [2:0]         len;
    logic [5:0][7:0]    tail;
    logic [ADDR_W-1:0]  idx;
  } icd_s_t;

  icd_s_t s;
  icd_s_t next_s;

  function automatic logic [ADDR_W-1:0] base_of(input logic [1:0] sel);
    unique case (sel) // [RULE13]
      icd_pkg::BASE_A: base_of = gen_ptr_a;
      icd_pkg::BASE_B: base_of = gen_ptr_b;
      icd_pkg::BASE_C: base_of = gen_ptr_c;
      icd_pkg::BASE_PB: base_of = param_block_ptr;
    endcase
  endfunction : base_of

  function automatic logic [ADDR_W-1:0] ea_of(input logic [1:0] mode, input logic [1:0] sel,
                                              input logic [7:0] off, input logic [ADDR_W-1:0] ix);
    unique case (mode) // [RULE10]
      icd_pkg::MODE_BASE:   ea_of = base_of(sel);
      icd_pkg::MODE_OFFSET: ea_of = base_of(sel) + {{(ADDR_W-8){1'b0}}, off}; // [RULE14]
      default:              ea_of = base_of(sel) + ix; // [RULE15] zero-extended, wraps in 64k
    endcase
  endfunction : ea_of

  // decode of the two head bytes: family and byte count
  logic [1:0]   xl;
  logic [1:0]   md;
  logic [5:0]   opc;
  logic         mem_form;
  logic         reg_form;
  logic [2:0]   dec_len;
  logic         dec_bad;
  icd_pkg::icd_fam_t dec_fam;
  logic [2:0]   off_n;

  always_comb begin
    xl       = s.b1[icd_pkg::XLEN_LSB +: 2]; // [RULE5]
    md       = s.b1[icd_pkg::MODE_LSB +: 2];
    opc      = s.b2[7:2]; // [RULE12]
    mem_form = 1'b1;
    reg_form = (md == icd_pkg::MODE_BASE);
    off_n    = (md == icd_pkg::MODE_OFFSET) ? 3'h1 : 3'h0;
    dec_bad  = 1'b0;
    dec_fam  = icd_pkg::ICD_FAM_NONE;
    if (s.b1[4:0] == icd_pkg::B1_FAR_IMM_LO && s.b2 == icd_pkg::B2_FAR_IMM) begin
      dec_fam = icd_pkg::ICD_FAM_FAR_IMM; // [RULE19]
      off_n   = 3'h0;
    end else if (reg_form && xl != icd_pkg::XLEN_NONE && s.b2[1:0] == icd_pkg::BASE_A) begin
      off_n = 3'h0;
      unique case (opc)
        icd_pkg::OP_SUMI_REG:  dec_fam = icd_pkg::ICD_FAM_SUMI_REG; // [RULE22]
        icd_pkg::OP_LOADI_REG: dec_fam = icd_pkg::ICD_FAM_LOADI_REG;
        default:               dec_bad = 1'b1;
      endcase
    end else begin
      unique case (opc)
        icd_pkg::OP_COPY_M2R: dec_fam = icd_pkg::ICD_FAM_COPY_M2R; // [RULE18]
        icd_pkg::OP_COPY_R2M: dec_fam = icd_pkg::ICD_FAM_COPY_R2M; // [RULE18]
        icd_pkg::OP_MM_SRC:   dec_fam = icd_pkg::ICD_FAM_COPY_MM; // [RULE17]
        icd_pkg::OP_PTR_M2P:  dec_fam = icd_pkg::ICD_FAM_PTR_M2P; // [RULE20]
        icd_pkg::OP_PTR_P2M:  dec_fam = icd_pkg::ICD_FAM_PTR_P2M; // [RULE20]
        icd_pkg::OP_FAR_VAR:  dec_fam = icd_pkg::ICD_FAM_FAR_VAR;
        icd_pkg::OP_SUM_M2R:  dec_fam = icd_pkg::ICD_FAM_SUM_M2R; // [RULE21]
        icd_pkg::OP_SUM_R2M:  dec_fam = icd_pkg::ICD_FAM_SUM_R2M; // [RULE21]
        icd_pkg::OP_SUMI_MEM: dec_fam = icd_pkg::ICD_FAM_SUMI_MEM; // [RULE22]
        icd_pkg::OP_LOADI_MEM: dec_fam = icd_pkg::ICD_FAM_LOADI_MEM;
        icd_pkg::OP_LOCK_SET: dec_fam = icd_pkg::ICD_FAM_LOCK_SET;
        icd_pkg::OP_CDOWN:    dec_fam = icd_pkg::ICD_FAM_CDOWN; // [RULE12]
        default:              dec_bad = 1'b1;
      endcase
    end
    mem_form = !dec_bad;
    // per-family consistency of the extra-length field and selector
    unique case (dec_fam)
      icd_pkg::ICD_FAM_LOCK_SET: dec_bad = (xl != icd_pkg::XLEN_LOCK); // [RULE6]
      icd_pkg::ICD_FAM_SUMI_REG, icd_pkg::ICD_FAM_LOADI_REG,
      icd_pkg::ICD_FAM_SUMI_MEM, icd_pkg::ICD_FAM_LOADI_MEM:
        dec_bad = (xl == icd_pkg::XLEN_NONE || xl == icd_pkg::XLEN_LOCK) ||
                  ((xl == icd_pkg::XLEN_TWO) != s.b1[icd_pkg::SIZE_BIT]); // [RULE8]
      icd_pkg::ICD_FAM_PTR_M2P, icd_pkg::ICD_FAM_PTR_P2M, icd_pkg::ICD_FAM_FAR_VAR:
        dec_bad = (xl != icd_pkg::XLEN_NONE) || !s.b1[icd_pkg::SIZE_BIT] || !ptr_ok(s.b1[7:5]); // [RULE20]
      icd_pkg::ICD_FAM_FAR_IMM: dec_bad = !ptr_ok(s.b1[7:5]); // [RULE4]
      icd_pkg::ICD_FAM_COPY_MM: dec_bad = (xl != icd_pkg::XLEN_NONE) || (s.b1[7:5] != icd_pkg::B1_MM_SEL);
      icd_pkg::ICD_FAM_NONE:    dec_bad = 1'b1; // [RULE23]
      default:                  dec_bad = dec_bad || (xl == icd_pkg::XLEN_LOCK); // [RULE6]
    endcase
    // length: head + offset + extra bytes [RULE9]
    unique case (dec_fam)
      icd_pkg::ICD_FAM_FAR_IMM: dec_len = icd_pkg::LEN_LONG; // [RULE1]
      icd_pkg::ICD_FAM_COPY_MM: dec_len = icd_pkg::LEN_LONG; // [RULE1] replaced by mm_len after byte four, or five with a source offset
      icd_pkg::ICD_FAM_LOCK_SET: dec_len = icd_pkg::LEN_BASE + off_n + 3'h2; // [RULE6]
      default: dec_len = icd_pkg::LEN_BASE + off_n + {1'b0, xl}; // [RULE5]
    endcase
  end

  function automatic logic ptr_ok(input logic [2:0] sel);
    ptr_ok = (sel == 3'h0) || (sel == 3'h1) || (sel == 3'h2) || (sel == 3'h4); // [RULE4]
  endfunction : ptr_ok

  // copy memory-memory total: each half adds its own offset byte
  logic [2:0] mm_len;
  always_comb begin
    mm_len = icd_pkg::LEN_BASE + icd_pkg::LEN_BASE
           + ((s.b1[icd_pkg::MODE_LSB +: 2] == icd_pkg::MODE_OFFSET) ? 3'h1 : 3'h0)
           + ((s.tail[off_n][icd_pkg::MODE_LSB +: 2] == icd_pkg::MODE_OFFSET) ? 3'h1 : 3'h0);
  end

  // no byte may be taken in a cycle that ends the instruction, or it would be lost
  logic tail_full;
  always_comb begin
    if (s.cnt == icd_pkg::LEN_BASE) tail_full = dec_bad || (dec_len == icd_pkg::LEN_BASE);
    else tail_full = (s.cnt >= s.len);
    tail_full = tail_full && (s.st == ICD_TAIL);
  end
  assign byte_ready = (s.st != ICD_DONE) && !tail_full; // [RULE2]

  always_comb begin
    next_s = s;
    unique case (s.st)
      ICD_IDLE: if (byte_valid) begin
        next_s.b1  = byte_data; // [RULE2]
        next_s.cnt = 3'h1;
        next_s.st  = ICD_HEAD;
      end
      ICD_HEAD: if (byte_valid) begin
        next_s.b2  = byte_data; // [RULE2]
        next_s.cnt = icd_pkg::LEN_BASE;
        next_s.st  = ICD_TAIL;
      end
      ICD_TAIL: begin
        if (s.cnt == icd_pkg::LEN_BASE) next_s.len = dec_len;
        if (dec_bad && s.cnt == icd_pkg::LEN_BASE) begin
          next_s.len = icd_pkg::LEN_BASE;
          next_s.st  = ICD_DONE; // [RULE23]
        end else if (s.cnt >= s.len && s.cnt != icd_pkg::LEN_BASE) begin
          next_s.st = ICD_DONE;
        end else if (dec_len == icd_pkg::LEN_BASE && s.cnt == icd_pkg::LEN_BASE) begin
          next_s.st = ICD_DONE;
        end else if (byte_valid) begin
          next_s.tail[s.cnt - icd_pkg::LEN_BASE] = byte_data;
          next_s.cnt = s.cnt + 3'h1;
          if (dec_fam == icd_pkg::ICD_FAM_COPY_MM && s.cnt + 3'h1 == 3'h3 + 3'h1 + off_n)
            next_s.len = mm_len; // [RULE17]
        end
      end
      ICD_DONE: next_s.st = ICD_IDLE;
    endcase
    if (byte_accessed && md_incr()) next_s.idx = s.idx + {{(ADDR_W-1){1'b0}}, 1'b1}; // [RULE16]
    if (s.st == ICD_IDLE && byte_valid) next_s.idx = index_reg;
  end

  function automatic logic md_incr();
    md_incr = (s.b1[icd_pkg::MODE_LSB +: 2] == icd_pkg::MODE_INCR) && (s.st == ICD_DONE);
  endfunction : md_incr

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs from state flip-flops; eff_addr and dst_addr also use the live base pointer inputs
  logic [7:0] off_b;
  logic [2:0] dat_at;
  always_comb begin
    off_b  = (md == icd_pkg::MODE_OFFSET) ? s.tail[0] : 8'h00;
    dat_at = off_n; // [RULE9]
  end
  assign done       = (s.st == ICD_DONE);
  assign illegal    = done && (s.len == icd_pkg::LEN_BASE) && dec_bad;
  assign instr_len  = done ? s.len : 3'h0; // [RULE24]
  assign family     = dec_bad ? icd_pkg::ICD_FAM_NONE : dec_fam;
  assign op_sel     = s.b1[icd_pkg::SEL_LSB +: 3]; // [RULE3]
  assign sel_ptr_ok = ptr_ok(s.b1[icd_pkg::SEL_LSB +: 3]);
  assign word_op    = s.b1[icd_pkg::SIZE_BIT]; // [RULE11]
  assign addr_mode  = md;
  assign base_sel   = s.b2[1:0];
  assign offset     = off_b;
  assign imm_data   = (dec_fam == icd_pkg::ICD_FAM_FAR_IMM) ? {s.tail[1], s.tail[0]} :
                      (word_op ? {s.tail[dat_at + 3'h1], s.tail[dat_at]} : {8'h00, s.tail[dat_at]}); // [RULE8]
  // short displacement is sign-extended; lock_test_set puts it after the data byte
  assign disp       = (dec_fam == icd_pkg::ICD_FAM_LOCK_SET) ? {{8{s.tail[dat_at + 3'h1][7]}}, s.tail[dat_at + 3'h1]} :
                      (xl == icd_pkg::XLEN_TWO) ? {s.tail[dat_at + 3'h1], s.tail[dat_at]} :
                      {{8{s.tail[dat_at][7]}}, s.tail[dat_at]}; // [RULE7]
  assign eff_addr   = ea_of(md, s.b2[1:0], off_b, s.idx);
  assign dst_addr   = ea_of(s.tail[off_n][icd_pkg::MODE_LSB +: 2], s.tail[off_n + 3'h1][1:0],
                            s.tail[off_n + 3'h2], s.idx); // [RULE17]
  assign index_next = s.idx;

  property p_len_range;
    @(posedge ref_clk) disable iff (!reset_n)
      (done && !illegal) |-> ((instr_len >= icd_pkg::LEN_BASE && instr_len <= icd_pkg::LEN_MAX_N) ||
                              (instr_len == icd_pkg::LEN_LONG &&
                               (family == icd_pkg::ICD_FAM_FAR_IMM || family == icd_pkg::ICD_FAM_COPY_MM)));
  endproperty
  a_len_range: assert property (p_len_range) else $error("instruction length out of range"); // [RULE1]

  property p_illegal_len;
    @(posedge ref_clk) disable iff (!reset_n)
      illegal |-> (done && instr_len == icd_pkg::LEN_BASE);
  endproperty
  a_illegal_len: assert property (p_illegal_len) else $error("illegal flag without two-byte done"); // [RULE23]

  property p_done_pulse;
    @(posedge ref_clk) disable iff (!reset_n)
      done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held longer than one cycle"); // [RULE24]

  property p_no_take_full;
    @(posedge ref_clk) disable iff (!reset_n)
      (s.st == ICD_TAIL && s.cnt != icd_pkg::LEN_BASE && s.cnt >= s.len) |-> !byte_ready;
  endproperty
  a_no_take_full: assert property (p_no_take_full) else $error("byte offered past end of instruction"); // [RULE2]

  property p_lock_only;
    @(posedge ref_clk) disable iff (!reset_n)
      (done && !illegal && xl == icd_pkg::XLEN_LOCK) |-> (family == icd_pkg::ICD_FAM_LOCK_SET);
  endproperty
  a_lock_only: assert property (p_lock_only) else $error("extra-length code 11 on other instruction"); // [RULE6]

  property p_ptr_sel;
    @(posedge ref_clk) disable iff (!reset_n)
      (done && !illegal && (family == icd_pkg::ICD_FAM_PTR_M2P || family == icd_pkg::ICD_FAM_PTR_P2M ||
                            family == icd_pkg::ICD_FAM_FAR_IMM)) |-> sel_ptr_ok;
  endproperty
  a_ptr_sel: assert property (p_ptr_sel) else $error("pointer instruction with invalid selector"); // [RULE4]

  property p_idx_incr;
    @(posedge ref_clk) disable iff (!reset_n)
      (byte_accessed && done && addr_mode == icd_pkg::MODE_INCR) |=>
        (index_next == $past(index_next) + {{(ADDR_W-1){1'b0}}, 1'b1});
  endproperty
  a_idx_incr: assert property (p_idx_incr) else $error("index not advanced after byte access"); // [RULE16]
endmodule : icd_decoder

// *** icd_pkg.sv ***
package icd_pkg;
  // first byte fields
  localparam int SEL_LSB    = 5;
  localparam int XLEN_LSB   = 3;
  localparam int MODE_LSB   = 1;
  localparam int SIZE_BIT   = 0;
  // extra-length codes
  localparam logic [1:0] XLEN_NONE = 2'h0;
  localparam logic [1:0] XLEN_ONE  = 2'h1;
  localparam logic [1:0] XLEN_TWO  = 2'h2;
  localparam logic [1:0] XLEN_LOCK = 2'h3;
  // addressing modes
  localparam logic [1:0] MODE_BASE   = 2'h0;
  localparam logic [1:0] MODE_OFFSET = 2'h1;
  localparam logic [1:0] MODE_INDEX  = 2'h2;
  localparam logic [1:0] MODE_INCR   = 2'h3;
  // base select codes
  localparam logic [1:0] BASE_A  = 2'h0;
  localparam logic [1:0] BASE_B  = 2'h1;
  localparam logic [1:0] BASE_C  = 2'h2;
  localparam logic [1:0] BASE_PB = 2'h3;
  // register selector values
  localparam logic [2:0] REG_INDEX = 3'h5;
  // second byte opcodes (bits 7..2)
  localparam logic [5:0] OP_COPY_M2R   = 6'h20;
  localparam logic [5:0] OP_COPY_R2M   = 6'h21;
  localparam logic [5:0] OP_MM_SRC     = 6'h24;
  localparam logic [5:0] OP_MM_DST     = 6'h33;
  localparam logic [5:0] OP_PTR_M2P    = 6'h23;
  localparam logic [5:0] OP_PTR_P2M    = 6'h26;
  localparam logic [5:0] OP_FAR_VAR    = 6'h22;
  localparam logic [5:0] OP_SUM_M2R    = 6'h28;
  localparam logic [5:0] OP_SUM_R2M    = 6'h34;
  localparam logic [5:0] OP_SUMI_MEM   = 6'h30;
  localparam logic [5:0] OP_LOADI_MEM  = 6'h13;
  localparam logic [5:0] OP_LOCK_SET   = 6'h25;
  localparam logic [5:0] OP_CDOWN      = 6'h3B;
  localparam logic [5:0] OP_SUMI_REG   = 6'h08;
  localparam logic [5:0] OP_LOADI_REG  = 6'h0C;
  localparam logic [5:0] OP_CDOWN_REG  = 6'h0F;
  // full byte and first-byte field codes
  localparam logic [7:0] B2_FAR_IMM    = 8'h08;
  localparam logic [4:0] B1_FAR_IMM_LO = 5'h11;
  localparam logic [2:0] B1_MM_SEL     = 3'h0;
  // lengths in bytes
  localparam logic [2:0] LEN_BASE  = 3'h2;
  localparam logic [2:0] LEN_LONG  = 3'h6;
  localparam logic [2:0] LEN_MAX_N = 3'h5;
  // family codes reported to the fetch unit
  typedef enum logic [3:0] {
    ICD_FAM_NONE, ICD_FAM_COPY_M2R, ICD_FAM_COPY_R2M, ICD_FAM_COPY_MM,
    ICD_FAM_PTR_M2P, ICD_FAM_PTR_P2M, ICD_FAM_FAR_IMM, ICD_FAM_FAR_VAR,
    ICD_FAM_SUM_M2R, ICD_FAM_SUM_R2M, ICD_FAM_SUMI_REG, ICD_FAM_SUMI_MEM,
    ICD_FAM_LOADI_REG, ICD_FAM_LOADI_MEM, ICD_FAM_LOCK_SET, ICD_FAM_CDOWN
  } icd_fam_t;
endpackage : icd_pkg

// *** icd_fetch_model.sv ***
`timescale 1ns/10ps
module icd_fetch_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       byte_ready,
  input  wire logic       slow,
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  logic [7:0] pend[$];
  logic       took;

  task automatic push(input logic [7:0] b);
    pend.push_back(b);
  endtask : push

  initial begin
    byte_valid = 1'b0;
    byte_data  = 8'h5A;
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      took <= 1'b0;
    end else begin
      took <= byte_valid && byte_ready;
    end
  end

  // bytes leave strictly in stream order and each is held until taken
  always @(negedge ref_clk) begin
    if (took) begin
      void'(pend.pop_front());
    end
    if (!reset_n) begin
      byte_valid <= 1'b0;
      byte_data  <= ~byte_data;
    end else if (!byte_valid || took) begin
      if (pend.size() != 0 && !(slow && took)) begin
        byte_valid <= 1'b1;
        byte_data  <= pend[0];
      end else begin
        // idle bus shows a toggling pattern, not the last byte
        byte_valid <= 1'b0;
        byte_data  <= ~byte_data;
      end
    end
  end
endmodule : icd_fetch_model

// *** test_icd_decoder.sv ***
`timescale 1ns/10ps
module test_icd_decoder;
  typedef struct {
    logic [2:0]        len;
    logic              ill;
    icd_pkg::icd_fam_t fam;
    logic [2:0]        sel;
    logic              w;
    logic [1:0]        am;
    logic [1:0]        bs;
    logic [15:0]       eff;
    logic [15:0]       dst;
    logic [15:0]       imm;
    logic [15:0]       dsp;
    logic [5:0]        what;
    logic [7:0]        off;
  } icd_exp_t;
  logic              ref_clk, reset_n, byte_valid, byte_ready, byte_accessed, slow, done, illegal, sel_ptr_ok, word_op;
  logic [7:0]        byte_data, offset;
  logic [2:0]        instr_len, op_sel;
  logic [1:0]        addr_mode, base_sel;
  logic [15:0]       gen_ptr_a, gen_ptr_b, gen_ptr_c, param_block_ptr, index_reg, imm_data, disp, eff_addr, dst_addr;
  logic [15:0]       index_next;
  icd_pkg::icd_fam_t family;
  int                mismatches, compares, seed;
  icd_exp_t          expq[$];
  icd_exp_t          got;
  logic [7:0]        nq[$];

  icd_decoder #(.ADDR_W(16)) i_icd_decoder (
    .ref_clk(ref_clk), .reset_n(reset_n), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_ready(byte_ready), .gen_ptr_a(gen_ptr_a), .gen_ptr_b(gen_ptr_b), .gen_ptr_c(gen_ptr_c),
    .param_block_ptr(param_block_ptr), .index_reg(index_reg), .byte_accessed(byte_accessed), .done(done),
    .illegal(illegal), .instr_len(instr_len), .family(family), .op_sel(op_sel), .sel_ptr_ok(sel_ptr_ok),
    .word_op(word_op), .addr_mode(addr_mode), .base_sel(base_sel), .offset(offset), .imm_data(imm_data),
    .disp(disp), .eff_addr(eff_addr), .dst_addr(dst_addr), .index_next(index_next));

  icd_fetch_model i_icd_fetch_model (
    .ref_clk(ref_clk), .reset_n(reset_n), .byte_ready(byte_ready), .slow(slow),
    .byte_valid(byte_valid), .byte_data(byte_data));

  task automatic close_out();
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [7:0] rb();
    return 8'($random(seed));
  endfunction : rb

  function automatic logic [15:0] basev(input logic [1:0] s);
    case (s)
      2'h0: return gen_ptr_a;
      2'h1: return gen_ptr_b;
      2'h2: return gen_ptr_c;
      default: return param_block_ptr;
    endcase
  endfunction : basev

  task automatic send(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] t[$],
                      input icd_pkg::icd_fam_t fam, input logic [5:0] what,
                      input logic [15:0] imm = 16'h0, input logic [15:0] dsp = 16'h0);
    icd_exp_t e;
    e = '{len: 3'(2 + t.size()), ill: (fam == icd_pkg::ICD_FAM_NONE), fam: fam, sel: b1[7:5], w: b1[0],
          am: b1[2:1], bs: b2[1:0], eff: basev(b2[1:0]), dst: 16'h0, imm: imm, dsp: dsp, what: what,
          off: 8'h00};
    if (b1[2:1] == 2'h1) e.eff = e.eff + 16'(t[0]);
    if (b1[2:1] == 2'h1) e.off = t[0];
    if (b1[2]) e.eff = e.eff + index_reg;
    if (what[3]) e.dst = basev(t[2][1:0]) + 16'(t[3]);
    expq.push_back(e);
    i_icd_fetch_model.push(b1);
    i_icd_fetch_model.push(b2);
    foreach (t[k]) i_icd_fetch_model.push(t[k]);
  endtask : send

  task automatic batch();
    logic [7:0] o, d, h, r;
    logic [7:0] t[$];
    int         ps[4];
    ps = '{0, 1, 2, 4};
    for (int m = 0; m < 4; m++) begin
      for (int b = 0; b < 4; b++) begin
        o = rb();
        r = rb();
        t = {};
        if (m == 1) t = {o};
        send({r[7:5], 2'h0, 2'(m), 1'b1}, {6'b100001, 2'(b)}, t, icd_pkg::ICD_FAM_COPY_R2M, 6'h01);
        send({r[7:5], 2'h0, 2'(m), 1'b0}, {6'b100000, 2'(b)}, t, icd_pkg::ICD_FAM_COPY_M2R, 6'h01);
      end
    end
    o = rb();
    h = rb();
    d = rb();
    send(8'h03, {6'b100100, 2'h1}, '{o, 8'h03, {6'b110011, 2'h2}, h}, icd_pkg::ICD_FAM_COPY_MM, 6'h09);
    for (int s = 0; s < 4; s++) begin
      send({3'(ps[s]), 5'b00011}, {6'b100011, 2'(s)}, '{o}, icd_pkg::ICD_FAM_PTR_M2P, 6'h21);
      send({3'(ps[s]), 5'b00001}, {6'b100110, 2'h3}, nq, icd_pkg::ICD_FAM_PTR_P2M, 6'h21);
    end
    send({3'h4, 5'b10001}, 8'h08, '{rb(), rb(), rb(), rb()}, icd_pkg::ICD_FAM_FAR_IMM, 6'h00);
    send({3'h6, 5'b00010}, {6'b101000, 2'h1}, '{o}, icd_pkg::ICD_FAM_SUM_M2R, 6'h01);
    send({3'h7, 5'b00101}, {6'b110100, 2'h2}, nq, icd_pkg::ICD_FAM_SUM_R2M, 6'h01);
    send({3'h5, 5'b10001}, 8'h20, '{o, h}, icd_pkg::ICD_FAM_SUMI_REG, 6'h02, {h, o});
    send(8'h13, {6'b110000, 2'h3}, '{d, o, h}, icd_pkg::ICD_FAM_SUMI_MEM, 6'h03, {h, o});
    send({3'h1, 5'b01000}, 8'h30, '{o}, icd_pkg::ICD_FAM_LOADI_REG, 6'h10, {8'h00, o});
    send(8'h0A, {6'b010011, 2'h0}, '{d, o}, icd_pkg::ICD_FAM_LOADI_MEM, 6'h11, {8'h00, o});
    h = rb() | 8'h80;
    send(8'h1A, {6'b100101, 2'h1}, '{d, o, h}, icd_pkg::ICD_FAM_LOCK_SET, 6'h15, {8'h00, o}, {8'hFF, h});
    send(8'h00, {6'b111011, 2'h2}, nq, icd_pkg::ICD_FAM_CDOWN, 6'h01);
    send(8'h01, {6'b111011, 2'h0}, nq, icd_pkg::ICD_FAM_CDOWN, 6'h01);
    send(8'h00, 8'h04, nq, icd_pkg::ICD_FAM_NONE, 6'h00);
    send({3'h2, 5'b11001}, {6'b100000, 2'h0}, nq, icd_pkg::ICD_FAM_NONE, 6'h00);
  endtask : batch

  task automatic drain();
    int n;
    n = 0;
    while (expq.size() != 0 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    if (expq.size() != 0) begin
      mismatches++;
      close_out();
    end
  endtask : drain

  task automatic rnd_regs();
    gen_ptr_a       = 16'($random(seed));
    gen_ptr_b       = 16'($random(seed));
    gen_ptr_c       = 16'($random(seed));
    param_block_ptr = 16'($random(seed));
    index_reg       = 16'($random(seed));
  endtask : rnd_regs

  always @(negedge ref_clk) begin
    if (reset_n && done === 1'b1) begin
      if (expq.size() == 0) begin
        chk("unexpected done", 16'h0, 16'h1);
      end else begin
        got = expq.pop_front();
        chk("instr_len", 16'(got.len), 16'(instr_len));
        chk("illegal", 16'(got.ill), 16'(illegal));
        if (!got.ill) begin
          chk("family", 16'(got.fam), 16'(family));
          chk("op_sel", 16'(got.sel), 16'(op_sel));
          chk("word_op", 16'(got.w), 16'(word_op));
          chk("addr_mode", 16'(got.am), 16'(addr_mode));
          chk("base_sel", 16'(got.bs), 16'(base_sel));
          chk("offset", 16'(got.off), 16'(offset));
          chk("index_next", index_reg, index_next);
          if (got.what[0]) chk("eff_addr", got.eff, 16'(eff_addr));
          if (got.what[1]) chk("imm_data", got.imm, imm_data);
          if (got.what[4]) chk("imm_data low", 16'(got.imm[7:0]), 16'(imm_data[7:0]));
          if (got.what[2]) chk("disp", got.dsp, disp);
          if (got.what[3]) chk("dst_addr", got.dst, 16'(dst_addr));
          if (got.what[5]) chk("sel_ptr_ok", 16'h1, 16'(sel_ptr_ok));
        end
      end
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    #(40 * 20000);
    mismatches++;
    close_out();
  end

  initial begin
    seed          = 32'he64ad27a;
    reset_n       = 1'b0;
    slow          = 1'b0;
    byte_accessed = 1'b0;
    rnd_regs();
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    batch();
    drain();
    // second pass after a mid-run reset, with the fetch side pausing between bytes
    @(negedge ref_clk);
    reset_n = 1'b0;
    @(negedge ref_clk);
    chk("done in reset", 16'h0, 16'(done));
    chk("instr_len in reset", 16'h0, 16'(instr_len));
    rnd_regs();
    slow    = 1'b1;
    byte_accessed = 1'b1;
    reset_n = 1'b1;
    batch();
    drain();
    close_out();
  end
endmodule : test_icd_decoder
